// ### src/sfc_device.sv
// device end: command framing, mode tracking and modify-command gating
//
// Functional notes
// - Code 55h then deselect enters parallel mode
// - Parallel mode accepts only the listed commands
// - Code 45h or power cycle exits parallel
// - Host limits clock in parallel mode; sfc_host keeps the same DIV in both modes
// - Fast read refused in parallel mode
// - All bytes travel most significant bit first
// - First bit sampled on first rising edge
// - One-byte code, then address/data as needed
// - Host deselects after final bit
// - Reads drive output; host may stop anytime
// - Modify commands need byte-multiple clock count
// - Busy device ignores array access attempts
// - Sector n spans n*10000h to plus FFFFh
// - Parallel mode moves one byte per clock
`timescale 1ns/1ps
`default_nettype none
module sfc_device (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   sfc_link_if.dev link,
   // array side
   input wire logic arrayBusy,
   input wire logic [7:0] readData,
   output logic readReq,
   output logic [sfc_pkg::ADDR_BITS-1:0] readAddr,
   output logic cmdValid,
   output logic [7:0] cmdCode,
   output logic [sfc_pkg::ADDR_BITS-1:0] cmdAddr,
   output logic [sfc_pkg::SECTOR_BITS-1:0] cmdSector,
   output logic wrDataValid,
   output logic [7:0] wrData,
   output logic parMode
);
   import sfc_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] sclkSync_q, sclkSync_d;
   logic [1:0] csSync_q, csSync_d;
   logic [7:0] dinMeta_q, dinMeta_d, din_q, din_d;
   logic sclkOld_q, sclkOld_d, csOld_q, csOld_d;
   logic rise, fall, frameStart, frameEnd, csLow;

   // two flops before any logic looks at a pin
   always_comb begin
      sclkSync_d = {sclkSync_q[0], link.sclk};
      csSync_d = {csSync_q[0], link.csN};
      dinMeta_d = link.wire8;
      din_d = dinMeta_q;
      sclkOld_d = sclkSync_q[1];
      csOld_d = csSync_q[1];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclkSync_q <= 2'h0;
         csSync_q <= 2'h3;
         dinMeta_q <= 8'hFF;
         din_q <= 8'hFF;
         sclkOld_q <= 1'b0;
         csOld_q <= 1'b1;
      end else begin
         sclkSync_q <= sclkSync_d;
         csSync_q <= csSync_d;
         dinMeta_q <= dinMeta_d;
         din_q <= din_d;
         sclkOld_q <= sclkOld_d;
         csOld_q <= csOld_d;
      end
   end

   // edges are taken from the second flop so data and clock stay aligned
   assign csLow = ~csSync_q[1];
   assign rise = sclkSync_q[1] & ~sclkOld_q & csLow;
   assign fall = ~sclkSync_q[1] & sclkOld_q & csLow;
   assign frameStart = ~csSync_q[1] & csOld_q;
   assign frameEnd = csSync_q[1] & ~csOld_q;

   // ----------------------------------------------------------------
   // frame decoder
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {SFC_IDLE, SFC_CODE, SFC_ADDR, SFC_WDATA, SFC_RDATA,
                             SFC_DISCARD} sfc_state_t;
   sfc_state_t state_q, state_d;
   logic par_q, par_d, parPend_q, parPend_d, exitPend_q, exitPend_d;
   logic [7:0] shift_q, shift_d, code_q, code_d, out_q, out_d;
   logic [2:0] bitCnt_q, bitCnt_d;
   logic [1:0] addrLeft_q, addrLeft_d;
   logic [ADDR_BITS-1:0] addr_q, addr_d;
   logic modPend_q, modPend_d, cmdValid_q, cmdValid_d, rdReq_q, rdReq_d;
   logic wrValid_q, wrValid_d, oe_q, oe_d;
   logic [7:0] byteIn;
   logic byteDone;

   // in parallel mode the whole lane is one byte per rising edge
   always_comb begin
      byteIn = par_q ? din_q : {shift_q[6:0], din_q[0]};
      byteDone = rise & (par_q | (bitCnt_q == 3'h7));
   end

   always_comb begin
      state_d = state_q;
      par_d = par_q;
      parPend_d = parPend_q;
      exitPend_d = exitPend_q;
      shift_d = shift_q;
      code_d = code_q;
      bitCnt_d = bitCnt_q;
      addrLeft_d = addrLeft_q;
      addr_d = addr_q;
      modPend_d = modPend_q;
      cmdValid_d = 1'b0;
      rdReq_d = 1'b0;
      wrValid_d = 1'b0;
      out_d = out_q;
      oe_d = oe_q;
      if (rise) begin
         shift_d = byteIn;
         bitCnt_d = bitCnt_q + 3'h1;
      end
      // output changes on the falling edge, msb first
      if (fall && state_q == SFC_RDATA && !par_q) begin
         out_d = {out_q[6:0], 1'b1};
      end
      if (frameStart) begin
         state_d = SFC_CODE;
         bitCnt_d = 3'h0;
         modPend_d = 1'b0;
         parPend_d = 1'b0;
         exitPend_d = 1'b0;
      end else if (frameEnd) begin
         state_d = SFC_IDLE;
         oe_d = 1'b0;
         if (parPend_q && bitCnt_q == 3'h0) par_d = 1'b1;
         if (exitPend_q && bitCnt_q == 3'h0) par_d = 1'b0;
         // count since select must be a whole number of bytes
         if (modPend_q && (par_q || bitCnt_q == 3'h0)) cmdValid_d = 1'b1;
      end else if (byteDone) begin
         bitCnt_d = 3'h0;
         case (state_q)
            SFC_CODE: begin
               code_d = byteIn;
               addrLeft_d = sfc_addr_bytes(byteIn);
               case (sfc_classify(byteIn, par_q))
                  SFC_KIND_READ: begin
                     // a busy array ignores reads entirely
                     if (arrayBusy) state_d = SFC_DISCARD;
                     else if (sfc_addr_bytes(byteIn) != 2'h0) state_d = SFC_ADDR;
                     else begin
                        state_d = SFC_RDATA;
                        rdReq_d = 1'b1;
                     end
                  end
                  SFC_KIND_MODIFY: begin
                     modPend_d = ~arrayBusy;
                     state_d = (sfc_addr_bytes(byteIn) != 2'h0) ? SFC_ADDR : SFC_WDATA;
                  end
                  SFC_KIND_MODE: begin
                     parPend_d = (byteIn == CMD_PAR_ENTER);
                     exitPend_d = (byteIn == CMD_PAR_EXIT);
                     state_d = SFC_WDATA;
                  end
                  // fast read lands here in parallel mode
                  default: state_d = SFC_DISCARD;
               endcase
            end
            SFC_ADDR: begin
               addr_d = {addr_q[ADDR_BITS-9:0], byteIn};
               addrLeft_d = addrLeft_q - 2'h1;
               if (addrLeft_q == 2'h1 && sfc_classify(code_q, par_q) == SFC_KIND_READ) begin
                  state_d = SFC_RDATA;
                  rdReq_d = 1'b1;
               end else if (addrLeft_q == 2'h1) begin
                  state_d = SFC_WDATA;
               end
            end
            SFC_WDATA: begin
               // extra bytes after a mode code cancel it
               parPend_d = 1'b0;
               exitPend_d = 1'b0;
               wrValid_d = modPend_q;
            end
            SFC_RDATA: rdReq_d = 1'b1;
            default: state_d = state_q;
         endcase
      end
      // next byte of read data loads after the request lands
      if (rdReq_q) begin
         out_d = readData;
         oe_d = 1'b1;
         addr_d = addr_q + 24'h000001;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= SFC_IDLE;
         par_q <= 1'b0;
         parPend_q <= 1'b0;
         exitPend_q <= 1'b0;
         shift_q <= 8'h00;
         code_q <= 8'h00;
         bitCnt_q <= 3'h0;
         addrLeft_q <= 2'h0;
         addr_q <= 24'h000000;
         modPend_q <= 1'b0;
         cmdValid_q <= 1'b0;
         rdReq_q <= 1'b0;
         wrValid_q <= 1'b0;
         out_q <= IDLE_FILL;
         oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         par_q <= par_d;
         parPend_q <= parPend_d;
         exitPend_q <= exitPend_d;
         shift_q <= shift_d;
         code_q <= code_d;
         bitCnt_q <= bitCnt_d;
         addrLeft_q <= addrLeft_d;
         addr_q <= addr_d;
         modPend_q <= modPend_d;
         cmdValid_q <= cmdValid_d;
         rdReq_q <= rdReq_d;
         wrValid_q <= wrValid_d;
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // serial output sits on lane bit 1; parallel uses the whole lane
   assign link.devData = par_q ? out_q : {6'h3F, out_q[7], 1'b1};
   assign link.devDataOe = oe_q & csLow;
   assign readReq = rdReq_q;
   assign readAddr = addr_q;
   assign cmdValid = cmdValid_q;
   assign cmdCode = code_q;
   assign cmdAddr = addr_q;
   assign cmdSector = addr_q[SECTOR_SHIFT +: SECTOR_BITS];
   assign wrDataValid = wrValid_q;
   assign wrData = shift_q;
   assign parMode = par_q;
endmodule : sfc_device
`default_nettype wire

// ### pkg/sfc_pkg.sv
// package: command codes, framing constants and types for the serial flash command front end
package sfc_pkg;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_PAR_ENTER = 8'h55;
   localparam logic [7:0] CMD_PAR_EXIT = 8'h45;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_FAST_READ = 8'h0B;
   localparam logic [7:0] CMD_WRITE_LATCH_SET = 8'h06;
   localparam logic [7:0] CMD_WRITE_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
   localparam logic [7:0] CMD_SECTOR_CLEAR = 8'hD8;
   localparam logic [7:0] CMD_SECTOR_CLEAR_ALT = 8'h20;
   localparam logic [7:0] CMD_WHOLE_CLEAR = 8'hC7;
   localparam logic [7:0] CMD_WHOLE_CLEAR_ALT = 8'h60;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_STATUS_READ = 8'h05;
   localparam logic [7:0] CMD_WAKE_SIGNATURE = 8'hAB;
   localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
   localparam logic [7:0] CMD_IDENTITY_READ = 8'h9F;
   localparam logic [7:0] CMD_MAKER_PART_READ = 8'h90;
   // ----------------------------------------------------------------
   // framing and address map
   // ----------------------------------------------------------------
   localparam int BYTE_BITS = 8;
   localparam int ADDR_BYTES = 3;
   localparam int ADDR_BITS = 24;
   localparam int SECTOR_SHIFT = 16;
   localparam int SECTOR_BITS = 8;
   localparam logic [15:0] SECTOR_OFFSET_MAX = 16'hFFFF;
   localparam int LINK_DIV = 4;
   localparam logic [7:0] IDLE_FILL = 8'hFF;

   typedef enum logic [1:0] {SFC_KIND_NONE, SFC_KIND_READ, SFC_KIND_MODIFY, SFC_KIND_MODE} sfc_kind_t;

   // classify a command for the current mode
   function automatic sfc_kind_t sfc_classify(input logic [7:0] code, input logic par);
      sfc_kind_t k;
      k = SFC_KIND_NONE;
      case (code)
         CMD_READ, CMD_STATUS_READ, CMD_IDENTITY_READ, CMD_MAKER_PART_READ,
         CMD_WAKE_SIGNATURE: k = SFC_KIND_READ;
         CMD_FAST_READ: k = par ? SFC_KIND_NONE : SFC_KIND_READ;
         CMD_WRITE_LATCH_SET, CMD_WRITE_LATCH_CLEAR, CMD_PAGE_WRITE, CMD_SECTOR_CLEAR,
         CMD_SECTOR_CLEAR_ALT, CMD_WHOLE_CLEAR, CMD_WHOLE_CLEAR_ALT, CMD_STATUS_WRITE,
         CMD_DEEP_SLEEP: k = SFC_KIND_MODIFY;
         CMD_PAR_ENTER, CMD_PAR_EXIT: k = SFC_KIND_MODE;
         default: k = SFC_KIND_NONE;
      endcase
      return k;
   endfunction : sfc_classify

   // number of address bytes a command carries
   function automatic logic [1:0] sfc_addr_bytes(input logic [7:0] code);
      logic [1:0] n;
      n = 2'h0;
      if (code == CMD_READ || code == CMD_FAST_READ || code == CMD_PAGE_WRITE ||
          code == CMD_SECTOR_CLEAR || code == CMD_SECTOR_CLEAR_ALT ||
          code == CMD_MAKER_PART_READ) begin
         n = 2'(ADDR_BYTES);
      end
      return n;
   endfunction : sfc_addr_bytes
endpackage : sfc_pkg

// ### pkg/sfc_link_if.sv
// interface: the serial/parallel flash link between host and device
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if;
   logic sclk;
   logic csN;
   logic [7:0] hostData;
   logic hostDataOe;
   logic [7:0] devData;
   logic devDataOe;
   logic [7:0] wire8;
   // shared byte lane: bit 0 is host-to-device serial, bit 1 device-to-host serial
   assign wire8 = devDataOe ? devData : (hostDataOe ? hostData : 8'hFF);
   modport host (output sclk, output csN, output hostData, output hostDataOe, input wire8);
   modport dev (input sclk, input csN, output devData, output devDataOe, input wire8);
endinterface : sfc_link_if
`default_nettype wire

// ### src/sfc_host.sv
// host end: issues one command frame, shifts bytes msb first and collects read bytes
`timescale 1ns/1ps
`default_nettype none
module sfc_host #(
   parameter int DIV = sfc_pkg::LINK_DIV
)(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link
   sfc_link_if.host link,
   // user request: bytes to send, then bytes to read
   input wire logic parMode,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic [7:0] txByte,
   input wire logic txLast,
   input wire logic [7:0] rxCount,
   output logic txTake,
   output logic rxValid,
   output logic [7:0] rxByte,
   output logic done
);
   import sfc_pkg::*;

   if (DIV < 2 || DIV > 255) begin : gDivCheck
      $error("DIV out of range");
   end

   // ----------------------------------------------------------------
   // link clock divider and frame sequencer
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {HST_IDLE, HST_SEND, HST_RECV, HST_END} sfc_host_state_t;
   sfc_host_state_t state_q, state_d;
   logic [7:0] div_q, div_d, rxLeft_q, rxLeft_d, sh_q, sh_d, rx_q, rx_d;
   logic [2:0] bit_q, bit_d;
   logic sclk_q, sclk_d, cs_q, cs_d, last_q, last_d, rxv_q, rxv_d, done_q, done_d;
   logic [7:0] inMeta_q, inSync_q;
   logic tick;

   // slow edges: low half then high half; device samples on the rise
   assign tick = (div_q == 8'(DIV - 1));

   always_comb begin
      state_d = state_q;
      div_d = (state_q == HST_IDLE || tick) ? 8'h00 : div_q + 8'h01;
      rxLeft_d = rxLeft_q;
      sh_d = sh_q;
      rx_d = rx_q;
      bit_d = bit_q;
      sclk_d = sclk_q;
      cs_d = cs_q;
      last_d = last_q;
      rxv_d = 1'b0;
      done_d = 1'b0;
      txTake = 1'b0;
      case (state_q)
         HST_IDLE: if (reqValid) begin
            cs_d = 1'b0;
            sh_d = txByte;
            last_d = txLast;
            txTake = 1'b1;
            rxLeft_d = rxCount;
            bit_d = 3'h0;
            state_d = HST_SEND;
         end
         HST_SEND: if (tick) begin
            sclk_d = ~sclk_q;
            // after the rising edge the bit is taken; advance on the fall
            if (sclk_q) begin
               if (parMode || bit_q == 3'h7) begin
                  bit_d = 3'h0;
                  if (last_q) state_d = (rxLeft_q != 8'h00) ? HST_RECV : HST_END;
                  else begin
                     sh_d = txByte;
                     last_d = txLast;
                     txTake = 1'b1;
                  end
               end else begin
                  bit_d = bit_q + 3'h1;
                  sh_d = {sh_q[6:0], 1'b0};
               end
            end
         end
         HST_RECV: if (tick) begin
            sclk_d = ~sclk_q;
            if (!sclk_q) begin
               rx_d = parMode ? inSync_q : {rx_q[6:0], inSync_q[1]};
               if (parMode || bit_q == 3'h7) begin
                  bit_d = 3'h0;
                  rxv_d = 1'b1;
                  rxLeft_d = rxLeft_q - 8'h01;
                  // stop on a byte boundary once enough bytes arrived
                  if (rxLeft_q == 8'h01) state_d = HST_END;
               end else bit_d = bit_q + 3'h1;
            end
         end
         HST_END: if (tick) begin
            sclk_d = 1'b0;
            cs_d = 1'b1;
            done_d = 1'b1;
            state_d = HST_IDLE;
         end
         default: state_d = HST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= HST_IDLE;
         div_q <= 8'h00;
         rxLeft_q <= 8'h00;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         bit_q <= 3'h0;
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         last_q <= 1'b0;
         rxv_q <= 1'b0;
         done_q <= 1'b0;
         inMeta_q <= 8'hFF;
         inSync_q <= 8'hFF;
      end else begin
         state_q <= state_d;
         div_q <= div_d;
         rxLeft_q <= rxLeft_d;
         sh_q <= sh_d;
         rx_q <= rx_d;
         bit_q <= bit_d;
         sclk_q <= sclk_d;
         cs_q <= cs_d;
         last_q <= last_d;
         rxv_q <= rxv_d;
         done_q <= done_d;
         inMeta_q <= link.wire8;
         inSync_q <= inMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.sclk = sclk_q;
   assign link.csN = cs_q;
   // serial data on lane bit 0, parallel on the whole lane
   assign link.hostData = parMode ? sh_q : {7'h7F, sh_q[7]};
   assign link.hostDataOe = (state_q == HST_SEND);
   assign reqReady = (state_q == HST_IDLE);
   assign rxValid = rxv_q;
   assign rxByte = rx_q;
   assign done = done_q;
endmodule : sfc_host
`default_nettype wire

// ### testbench/sfc_checker.sv
// checker: framing and timing relations on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module sfc_checker #(
   parameter int DIV = sfc_pkg::LINK_DIV
)(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link signals
   input wire logic sclk,
   input wire logic csN,
   input wire logic [7:0] hostData,
   input wire logic devDataOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic sclk_q;
   logic [7:0] run_q;
   logic [7:0] run_d;

   // ----------------------------------------------------------------
   // helper: cycles the link clock has held its level
   // ----------------------------------------------------------------
   always_comb begin
      run_d = (sclk == sclk_q) ? run_q + 8'h01 : 8'h00;
   end
   // restarts on every level change, so only the high phase is exact
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclk_q <= 1'b0;
         run_q <= 8'h00;
      end else begin
         sclk_q <= sclk;
         run_q <= run_d;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_reset_idle: assert property ($fell(sys_rst) |-> csN && !sclk && !devDataOe)
      else $error("link not idle after reset");
   a_cs_edge_low: assert property ($changed(csN) |-> !sclk)
      else $error("select moved while link clock high");
   a_rise_in_frame: assert property ($rose(sclk) |-> !csN)
      else $error("link clock rose outside a frame");
   a_first_rise: assert property ($fell(csN) |-> (!sclk) [*2] ##[1:40] sclk)
      else $error("first link clock rise missing or early");
   a_high_phase: assert property ($fell(sclk) |-> run_q == 8'(DIV - 1))
      else $error("link clock high phase has wrong length");
   a_data_hold: assert property ($rose(sclk) |-> $stable(hostData) ##1 $stable(hostData))
      else $error("host data moved around a rising edge");
   a_dev_release: assert property (csN [*6] |-> !devDataOe)
      else $error("device drives lane while deselected");
   a_cs_high_min: assert property ($rose(csN) |-> csN [*2])
      else $error("select high pulse too short");
endmodule : sfc_checker
`default_nettype wire

// ### testbench/serial_flash_command_front_end_test.sv
// testbench: host and device ends joined, a bit driver that breaks framing, and the checker
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_front_end_test;
   import sfc_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reqValid = 1'b0;
   logic [7:0] txByte = 8'h00;
   logic txLast = 1'b0;
   logic [7:0] rxCount = 8'h00;
   logic arrayBusy = 1'b0;
   logic bbClk = 1'b0;
   logic bbCs = 1'b1;
   logic bbData = 1'b1;
   logic reqReady, txTake, rxValid, done, readReq, cmdValid, wrDataValid, parMode, cmdValid2;
   logic [7:0] rxByte, cmdCode, wrData, readData, gotCode, gotSector, firstLane, wireByte;
   logic [ADDR_BITS-1:0] readAddr, cmdAddr, gotAddr;
   logic [SECTOR_BITS-1:0] cmdSector;
   logic [7:0] wrQ[$];
   logic [7:0] rxQ[$];
   logic [7:0] txQ[$];
   int n_fail = 0;
   int checked = 0;
   int nReq = 0;
   int nCmd = 0;
   int nCmd2 = 0;
   int nRise = 0;

   initial begin
      forever #20 clk = ~clk;
   end
   // array model: data is a function of the address so a read can be predicted
   assign readData = readAddr[7:0] ^ 8'hA5;

   // ----------------------------------------------------------------
   // ends, second link with the bit driver, checker
   // ----------------------------------------------------------------
   sfc_link_if i_link ();
   sfc_link_if i_link2 ();
   assign i_link2.sclk = bbClk;
   assign i_link2.csN = bbCs;
   assign i_link2.hostData = {7'h7F, bbData};
   assign i_link2.hostDataOe = ~bbCs;
   sfc_host #(.DIV(LINK_DIV)) i_sfc_host (.clk(clk), .sys_rst(sys_rst), .link(i_link),
      .parMode(parMode), .reqValid(reqValid), .reqReady(reqReady), .txByte(txByte),
      .txLast(txLast), .rxCount(rxCount), .txTake(txTake), .rxValid(rxValid),
      .rxByte(rxByte), .done(done));
   sfc_device i_sfc_device (.clk(clk), .sys_rst(sys_rst), .link(i_link),
      .arrayBusy(arrayBusy), .readData(readData), .readReq(readReq), .readAddr(readAddr),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdSector(cmdSector),
      .wrDataValid(wrDataValid), .wrData(wrData), .parMode(parMode));
   sfc_device i_sfc_device_2 (.clk(clk), .sys_rst(sys_rst), .link(i_link2),
      .arrayBusy(1'b0), .readData(8'hFF), .readReq(), .readAddr(), .cmdValid(cmdValid2),
      .cmdCode(), .cmdAddr(), .cmdSector(), .wrDataValid(), .wrData(), .parMode());
   sfc_checker #(.DIV(LINK_DIV)) i_sfc_checker (.clk(clk), .sys_rst(sys_rst),
      .sclk(i_link.sclk), .csN(i_link.csN), .hostData(i_link.hostData),
      .devDataOe(i_link.devDataOe));

   // ----------------------------------------------------------------
   // monitors
   // ----------------------------------------------------------------
   // device pulses stand one cycle, so every edge is looked at
   always @(posedge clk) begin
      if (readReq === 1'b1) nReq++;
      if (cmdValid === 1'b1) begin
         nCmd++;
         gotCode = cmdCode;
         gotAddr = cmdAddr;
         gotSector = cmdSector;
      end
      if (wrDataValid === 1'b1) wrQ.push_back(wrData);
      if (cmdValid2 === 1'b1) nCmd2++;
   end
   // wire watcher: rises per frame, whole first lane and first serial byte
   always @(negedge i_link.csN) nRise = 0;
   always @(posedge i_link.sclk) begin
      if (i_link.csN === 1'b0) begin
         if (nRise == 0) firstLane = i_link.wire8;
         if (nRise < 8) wireByte = {wireByte[6:0], i_link.wire8[0]};
         nRise++;
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // one frame through the host end; comb handshakes are read mid-cycle, before the edge
   task automatic frame(input int nRx, input bit par);
      int idx;
      int sz;
      bit fin;
      bit tk;
      bit rq;
      idx = 0;
      sz = txQ.size();
      fin = 0;
      tk = 1;
      rxQ.delete();
      wrQ.delete();
      rxCount = 8'(nRx);
      txByte = txQ[0];
      txLast = (sz == 1);
      reqValid = 1'b1;
      #5 rq = reqReady === 1'b1;
      for (int n = 0; n < 8000 && !fin; n++) begin
         @(negedge clk);
         if (rxValid === 1'b1) rxQ.push_back(rxByte);
         if (done === 1'b1) fin = 1;
         if (tk && idx < sz - 1) idx++;
         if (rq) reqValid = 1'b0;
         txByte = txQ[idx];
         txLast = (idx == sz - 1);
         #5 tk = txTake === 1'b1;
         rq = reqValid && reqReady === 1'b1;
      end
      if (!fin) begin
         n_fail++;
         end_sim();
      end
      // device reports through a synchroniser, a few cycles after deselect
      repeat (8) @(negedge clk);
      if (par) begin
         chk(nRise, sz + nRx);
         chk(firstLane, txQ[0]);
      end else begin
         chk(nRise, 8 * (sz + nRx));
         chk(wireByte, txQ[0]);
      end
      chk(rxQ.size(), nRx);
   endtask : frame

   task automatic modCmd(input logic [7:0] code, input logic [23:0] addr, input bit ad,
         input bit par);
      int c0;
      bit dat;
      c0 = nCmd;
      dat = (code == CMD_PAGE_WRITE || code == CMD_STATUS_WRITE);
      txQ = '{code};
      if (ad) txQ = {txQ, addr[23:16], addr[15:8], addr[7:0]};
      if (dat) txQ.push_back(8'h3C);
      frame(0, par);
      chk(nCmd - c0, 1);
      chk(gotCode, code);
      if (ad) chk(gotAddr, addr);
      if (ad) chk(gotSector, addr >> 16);
      if (dat) chk(wrQ.size(), 1);
      if (dat) chk(wrQ[0], 8'h3C);
      $display("test command %h done", code);
   endtask : modCmd

   task automatic readCmd(input logic [23:0] addr, input bit par, input bit busy);
      int r0;
      r0 = nReq;
      arrayBusy = busy;
      txQ = '{CMD_READ, addr[23:16], addr[15:8], addr[7:0]};
      frame(1, par);
      arrayBusy = 1'b0;
      // a fetch at each byte boundary after the address
      chk(nReq - r0, busy ? 0 : 2);
      if (!busy) chk(readAddr, addr + 24'h000002);
      if (!busy) chk(rxQ[0], addr[7:0] ^ 8'hA5);
      $display("test read %h done", addr);
   endtask : readCmd

   task automatic fastCmd(input bit par);
      int r0;
      r0 = nReq;
      txQ = '{CMD_FAST_READ, 8'h00, 8'h10, 8'h00, 8'h00};
      frame(1, par);
      chk(nReq - r0, par ? 0 : 3);
      $display("test fast read done");
   endtask : fastCmd

   task automatic modeCmd(input logic [7:0] code, input bit par, input bit exp);
      txQ = '{code};
      frame(0, par);
      chk(parMode, exp);
      $display("test mode %h done", code);
   endtask : modeCmd

   // frame on the second link with any clock count; pins move on falling edges
   task automatic bang(input logic [7:0] code, input int nBits, input int exp);
      int c0;
      c0 = nCmd2;
      bbCs = 1'b0;
      for (int i = 0; i < nBits; i++) begin
         bbData = code[7 - (i % 8)];
         repeat (4) @(negedge clk);
         bbClk = 1'b1;
         repeat (4) @(negedge clk);
         bbClk = 1'b0;
      end
      repeat (4) @(negedge clk);
      bbCs = 1'b1;
      repeat (50) @(negedge clk);
      chk(nCmd2 - c0, exp);
      $display("test %0d clocks done", nBits);
   endtask : bang

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      chk(parMode, 1'b0);
      chk(i_link.csN, 1'b1);
      $display("test reset done");
      modCmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 0);
      modCmd(CMD_WRITE_LATCH_CLEAR, 24'h0, 0, 0);
      modCmd(CMD_WHOLE_CLEAR, 24'h0, 0, 0);
      modCmd(CMD_WHOLE_CLEAR_ALT, 24'h0, 0, 0);
      modCmd(CMD_STATUS_WRITE, 24'h0, 0, 0);
      modCmd(CMD_SECTOR_CLEAR, 24'hD10000, 1, 0);
      modCmd(CMD_SECTOR_CLEAR_ALT, 24'h00FFFF, 1, 0);
      modCmd(CMD_PAGE_WRITE, 24'h123456, 1, 0);
      readCmd(24'h0000A7, 0, 0);
      readCmd(24'h0000A7, 0, 1);
      fastCmd(0);
      modeCmd(CMD_PAR_ENTER, 0, 1);
      readCmd(24'hD10034, 1, 0);
      modCmd(CMD_SECTOR_CLEAR, 24'hD10000, 1, 1);
      modCmd(CMD_DEEP_SLEEP, 24'h0, 0, 1);
      fastCmd(1);
      modeCmd(CMD_PAR_EXIT, 1, 0);
      modeCmd(CMD_PAR_ENTER, 0, 1);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      chk(parMode, 1'b0);
      $display("test power cycle done");
      bang(CMD_WRITE_LATCH_SET, 8, 1);
      bang(CMD_WRITE_LATCH_SET, 9, 0);
      bang(CMD_WRITE_LATCH_CLEAR, 7, 0);
      end_sim();
   end
endmodule : serial_flash_command_front_end_test
`default_nettype wire
